// *** src/tm8_pkg.sv ***
// package: register map, field layout and constants of the 8-bit timer
package tm8_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_COMPARE = 5'h08;
    localparam logic [4:0] OFS_FLAGS = 5'h0C;
    localparam logic [4:0] OFS_IRQ_EN = 5'h10;
    localparam logic [4:0] OFS_PORT = 5'h14;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTION_LSB = 2;
    localparam int CTRL_CLKSEL_LSB = 4;
    localparam int CTRL_FORCE_BIT = 7;

    // flag / enable register fields
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_BIT = 1;

    // port register fields
    localparam int PORT_OUT_BIT = 0;
    localparam int PORT_DIR_BIT = 1;

    // waveform modes
    localparam logic [1:0] MODE_WRAP = 2'h0;
    localparam logic [1:0] MODE_PHASE_PWM = 2'h1;
    localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
    localparam logic [1:0] MODE_FAST_PWM = 2'h3;

    // compare-output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // counter extremes
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_PRESCALE = 10'h000;

    // prescaler tap widths (divide by 2**n) for clock selects 2..7
    localparam int PRE_DIV8_BITS = 3;
    localparam int PRE_DIV32_BITS = 5;
    localparam int PRE_DIV64_BITS = 6;
    localparam int PRE_DIV128_BITS = 7;
    localparam int PRE_DIV256_BITS = 8;
    localparam int PRE_DIV1024_BITS = 10;

endpackage : tm8_pkg

// *** src/tm8_timer.sv ***
// 8-bit timer/counter: wrap and clear-on-match modes, compare output
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - force strobe applies selected output action
// - forced compare leaves flag and counter
// - counter write blocks next tick's match
// - writing count equal compare loses match
// - output state kept across mode change
// - action field unbuffered, used next match
// - nonzero action overrides port output value
// - pin driven only when direction is output
// - action zero leaves output state unchanged
// - counting depends only on clock select
// - mode zero counts up, wraps max
// - overflow flag set when counter wraps
// - overflow interrupt service clears its flag
// - counter writable anytime in wrap mode
// - mode two clears counter on match
// - unbuffered compare, missed match wraps first
// - compare flag set every clear period
// - action one toggles output each match
// - prescale 1,8,32,64,128,256,1024 selectable
// - clear mode overflow on max to zero unless compare matches at max
// - match flag next tick, cleared by service/w1
// - counter write beats clear and count
// - select zero freezes counter, still accessible
// - compare value written directly, unbuffered
module tm8_timer
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_ovf_irq_ack,
    input wire logic i_cmp_irq_ack,
    output logic o_ovf_irq,
    output logic o_cmp_irq,
    output logic o_pin_out,
    output logic o_pin_oe_n
);

    // =========================================================
    // functions
    // =========================================================
    function automatic logic f_oc_next(input logic [1:0] act,
                                       input logic oc);
        logic r;
        r = oc;
        case (act)
            tm8_pkg::ACT_NONE: r = oc;
            tm8_pkg::ACT_TOGGLE: r = ~oc;
            tm8_pkg::ACT_CLEAR: r = 1'b0;
            tm8_pkg::ACT_SET: r = 1'b1;
            default: r = oc;
        endcase
        return r;
    endfunction : f_oc_next

    function automatic logic f_tick(input logic [2:0] sel,
                                    input logic [9:0] pre);
        logic r;
        r = 1'b0;
        case (sel)
            3'h0: r = 1'b0;
            3'h1: r = 1'b1;
            3'h2: r = &pre[tm8_pkg::PRE_DIV8_BITS-1:0];
            3'h3: r = &pre[tm8_pkg::PRE_DIV32_BITS-1:0];
            3'h4: r = &pre[tm8_pkg::PRE_DIV64_BITS-1:0];
            3'h5: r = &pre[tm8_pkg::PRE_DIV128_BITS-1:0];
            3'h6: r = &pre[tm8_pkg::PRE_DIV256_BITS-1:0];
            3'h7: r = &pre[tm8_pkg::PRE_DIV1024_BITS-1:0];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : f_tick

    function automatic logic f_non_pwm(input logic [1:0] mode);
        return (mode == tm8_pkg::MODE_WRAP) ||
               (mode == tm8_pkg::MODE_CLEAR_ON_MATCH);
    endfunction : f_non_pwm

    // =========================================================
    // registers
    // =========================================================
    logic [1:0] mode_ff;
    logic [1:0] action_ff;
    logic [2:0] clksel_ff;
    logic [7:0] count_ff;
    logic [7:0] compare_ff;
    logic ovf_flag_ff;
    logic cmp_flag_ff;
    logic ovf_ie_ff;
    logic cmp_ie_ff;
    logic port_out_ff;
    logic pin_dir_ff;
    logic oc_state_ff;
    logic block_ff;
    logic [9:0] pre_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic pin_out_ff;
    logic pin_oe_n_ff;
    logic ovf_irq_ff;
    logic cmp_irq_ff;

    // =========================================================
    // bus decode
    // =========================================================
    // a request is held until the edge where waitrequest is low;
    // that edge alone commits a write, so every access costs
    // exactly two cycles
    logic bus_req;
    logic bus_acc;
    logic wr_acc;
    logic lane0;
    logic ctrl_wr;
    logic count_wr;
    logic compare_wr;
    logic flags_wr;
    logic irq_en_wr;
    logic port_wr;
    logic [7:0] wbyte;

    assign bus_req = i_avs_read | i_avs_write;
    assign bus_acc = bus_req & ~wait_ff;
    assign wr_acc = bus_acc & i_avs_write;
    assign lane0 = i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];
    assign ctrl_wr = wr_acc & lane0 &
                     (i_avs_address == tm8_pkg::OFS_CTRL);
    assign count_wr = wr_acc & lane0 &
                      (i_avs_address == tm8_pkg::OFS_COUNT);
    assign compare_wr = wr_acc & lane0 &
                        (i_avs_address == tm8_pkg::OFS_COMPARE);
    assign flags_wr = wr_acc & lane0 &
                      (i_avs_address == tm8_pkg::OFS_FLAGS);
    assign irq_en_wr = wr_acc & lane0 &
                       (i_avs_address == tm8_pkg::OFS_IRQ_EN);
    assign port_wr = wr_acc & lane0 &
                     (i_avs_address == tm8_pkg::OFS_PORT);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            wait_ff <= 1'b1;
        else
            wait_ff <= ~(bus_req & wait_ff);
    end

    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = tm8_pkg::RST_BYTE;
        case (i_avs_address)
            tm8_pkg::OFS_CTRL:
                rd_byte = {1'b0, clksel_ff, action_ff, mode_ff};
            tm8_pkg::OFS_COUNT: rd_byte = count_ff;
            tm8_pkg::OFS_COMPARE: rd_byte = compare_ff;
            tm8_pkg::OFS_FLAGS:
                rd_byte = {6'h00, cmp_flag_ff, ovf_flag_ff};
            tm8_pkg::OFS_IRQ_EN:
                rd_byte = {6'h00, cmp_ie_ff, ovf_ie_ff};
            tm8_pkg::OFS_PORT:
                rd_byte = {6'h00, pin_dir_ff, port_out_ff};
            default: rd_byte = tm8_pkg::RST_BYTE;
        endcase
    end

    // data is captured in the wait cycle so it stands at the
    // accepting edge; unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rdata_ff <= 32'h0000_0000;
        else if (i_avs_read & wait_ff)
            rdata_ff <= {24'h00_0000, rd_byte};
    end

    // =========================================================
    // control and configuration
    // =========================================================
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mode_ff <= tm8_pkg::MODE_WRAP;
            action_ff <= tm8_pkg::ACT_NONE;
            clksel_ff <= 3'h0;
        end
        else if (ctrl_wr)
        begin
            mode_ff <= wbyte[tm8_pkg::CTRL_MODE_LSB +: 2];
            action_ff <= wbyte[tm8_pkg::CTRL_ACTION_LSB +: 2];
            clksel_ff <= wbyte[tm8_pkg::CTRL_CLKSEL_LSB +: 3];
        end
    end

    // compare value is written straight into the comparator
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            compare_ff <= tm8_pkg::RST_BYTE;
        else if (compare_wr)
            compare_ff <= wbyte;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ovf_ie_ff <= 1'b0;
            cmp_ie_ff <= 1'b0;
        end
        else if (irq_en_wr)
        begin
            ovf_ie_ff <= wbyte[tm8_pkg::FLAG_OVF_BIT];
            cmp_ie_ff <= wbyte[tm8_pkg::FLAG_CMP_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            port_out_ff <= 1'b0;
            pin_dir_ff <= 1'b0;
        end
        else if (port_wr)
        begin
            port_out_ff <= wbyte[tm8_pkg::PORT_OUT_BIT];
            pin_dir_ff <= wbyte[tm8_pkg::PORT_DIR_BIT];
        end
    end

    // =========================================================
    // prescaler and timer tick
    // =========================================================
    logic tick;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pre_ff <= tm8_pkg::RST_PRESCALE;
        else
            pre_ff <= pre_ff + 10'h001;
    end

    assign tick = f_tick(clksel_ff, pre_ff);

    // =========================================================
    // counter
    // =========================================================
    logic match_raw;
    logic match_ev;
    logic force_ev;
    logic wrap_ev;
    logic [7:0] nxt_count;

    assign match_raw = (count_ff == compare_ff);
    // a blocked match does nothing at all, including a match set
    // up by writing the compare value into the counter
    assign match_ev = tick & match_raw & ~block_ff;
    assign force_ev = ctrl_wr & wbyte[tm8_pkg::CTRL_FORCE_BIT] &
                      f_non_pwm(wbyte[tm8_pkg::CTRL_MODE_LSB +: 2]);
    assign wrap_ev = tick & (count_ff == tm8_pkg::CNT_MAX) &
                     ~((mode_ff == tm8_pkg::MODE_CLEAR_ON_MATCH) &
                       match_ev);

    // the pwm modes are outside this block and count as wrap mode
    always_comb
    begin
        nxt_count = count_ff;
        if (count_wr)
            nxt_count = wbyte;
        else if (tick)
        begin
            if ((mode_ff == tm8_pkg::MODE_CLEAR_ON_MATCH) && match_ev)
                nxt_count = tm8_pkg::CNT_BOTTOM;
            else
                nxt_count = count_ff + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            count_ff <= tm8_pkg::RST_BYTE;
        else
            count_ff <= nxt_count;
    end

    // the block holds until the next tick, however long the timer
    // stays stopped
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            block_ff <= 1'b0;
        else if (count_wr)
            block_ff <= 1'b1;
        else if (tick)
            block_ff <= 1'b0;
    end

    // =========================================================
    // flags
    // =========================================================
    // a setting event wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ovf_flag_ff <= 1'b0;
        else if (wrap_ev)
            ovf_flag_ff <= 1'b1;
        else if (i_ovf_irq_ack |
                 (flags_wr & wbyte[tm8_pkg::FLAG_OVF_BIT]))
            ovf_flag_ff <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cmp_flag_ff <= 1'b0;
        else if (match_ev)
            cmp_flag_ff <= 1'b1;
        else if (i_cmp_irq_ack |
                 (flags_wr & wbyte[tm8_pkg::FLAG_CMP_BIT]))
            cmp_flag_ff <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ovf_irq_ff <= 1'b0;
            cmp_irq_ff <= 1'b0;
        end
        else
        begin
            ovf_irq_ff <= ovf_flag_ff & ovf_ie_ff;
            cmp_irq_ff <= cmp_flag_ff & cmp_ie_ff;
        end
    end

    // =========================================================
    // compare output state and pin
    // =========================================================
    // the force uses the action written with it; it never touches
    // the counter or the flag
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            oc_state_ff <= 1'b0;
        else if (force_ev)
            oc_state_ff <= f_oc_next(
                wbyte[tm8_pkg::CTRL_ACTION_LSB +: 2],
                oc_state_ff);
        else if (match_ev & f_non_pwm(mode_ff))
            oc_state_ff <= f_oc_next(action_ff,
                                     oc_state_ff);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_out_ff <= 1'b0;
            pin_oe_n_ff <= 1'b1;
        end
        else
        begin
            pin_out_ff <= (action_ff != tm8_pkg::ACT_NONE) ?
                          oc_state_ff : port_out_ff;
            pin_oe_n_ff <= ~pin_dir_ff;
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_ovf_irq = ovf_irq_ff;
    assign o_cmp_irq = cmp_irq_ff;
    assign o_pin_out = pin_out_ff;
    assign o_pin_oe_n = pin_oe_n_ff;

    // =========================================================
    // assertions
    // =========================================================
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_cmp_flag_cause: assert property (
        $rose(cmp_flag_ff) |->
            $past(tick) && $past(match_raw) && !$past(block_ff))
        else $error("compare flag rose without a real match");

    a_block_after_write: assert property (
        count_wr |=> block_ff until_with tick)
        else $error("counter write did not block next match");

    a_clear_on_match: assert property (
        tick && !count_wr && match_ev &&
        mode_ff == tm8_pkg::MODE_CLEAR_ON_MATCH
        |=> count_ff == tm8_pkg::CNT_BOTTOM && cmp_flag_ff)
        else $error("counter not cleared on match");

    a_wrap_normal: assert property (
        tick && !count_wr && mode_ff == tm8_pkg::MODE_WRAP &&
        count_ff == tm8_pkg::CNT_MAX
        |=> count_ff == tm8_pkg::CNT_BOTTOM && ovf_flag_ff)
        else $error("wrap from max failed");

    a_ovf_cause: assert property (
        $rose(ovf_flag_ff) |->
            $past(tick) && $past(count_ff) == tm8_pkg::CNT_MAX)
        else $error("overflow flag set without wrap");

    a_toggle_match: assert property (
        match_ev && !force_ev && f_non_pwm(mode_ff) &&
        action_ff == tm8_pkg::ACT_TOGGLE
        |=> oc_state_ff != $past(oc_state_ff))
        else $error("output did not toggle on match");

    a_oc_change_cause: assert property (
        $changed(oc_state_ff) |->
            $past(force_ev) || $past(match_ev))
        else $error("output state changed without cause");

    a_action_zero_hold: assert property (
        action_ff == tm8_pkg::ACT_NONE && !ctrl_wr
        |=> $stable(oc_state_ff))
        else $error("output state moved with action zero");

    a_pin_override: assert property (
        ##1 o_pin_out == ($past(action_ff) != tm8_pkg::ACT_NONE ?
                          $past(oc_state_ff) : $past(port_out_ff)))
        else $error("pin output source wrong");

    a_count_write_prio: assert property (
        count_wr |=> count_ff == $past(wbyte))
        else $error("counter write lost");

    a_stopped_frozen: assert property (
        clksel_ff == 3'h0 && !count_wr |=> $stable(count_ff))
        else $error("stopped counter moved");

    a_bus_answer: assert property (
        bus_req && wait_ff |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest did not drop for one cycle");

endmodule : tm8_timer

// *** dv/tb_top.sv ***
// self-checking testbench for the 8-bit timer, compare output and counting
`timescale 1ns/1ps
module tb_top;
// ============================================================
// stimulus signals and device under test
logic i_clk = 1'b0;
logic i_rstn = 1'b0;
logic [4:0] adr = 5'h00;
logic rd_req = 1'b0;
logic wr_req = 1'b0;
logic [31:0] wdat = 32'h00000000;
logic ovf_ack = 1'b0;
logic cmp_ack = 1'b0;
logic [31:0] o_avs_readdata;
logic o_avs_waitrequest;
logic o_ovf_irq;
logic o_cmp_irq;
logic o_pin_out;
logic o_pin_oe_n;
int errors = 0;
int cmp_count = 0;

always #12.5 i_clk = ~i_clk;

tm8_timer uut
(
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_avs_address(adr),
    .i_avs_read(rd_req),
    .i_avs_write(wr_req),
    .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_ovf_irq_ack(ovf_ack),
    .i_cmp_irq_ack(cmp_ack),
    .o_ovf_irq(o_ovf_irq),
    .o_cmp_irq(o_cmp_irq),
    .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n)
);

// ============================================================
// shared tasks
task automatic wrap_up;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
    begin
        $display("*** PASS ***");
    end
    else
    begin
        $display("*** FAIL ***");
    end
    $finish;
endtask : wrap_up

task automatic chk(input string what, input logic [15:0] exp,
                   input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
        errors++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
    end
endtask : chk

task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
endtask : cyc

// one avalon access; held until waitrequest is sampled low
task automatic acc(input logic is_wr, input logic [4:0] a,
                   input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wr_req <= is_wr;
    rd_req <= ~is_wr;
    wdat <= {24'h000000, d};
    do
    begin
        @(posedge i_clk);
        n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 20);
    q = o_avs_readdata[7:0];
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    if (n >= 20)
    begin
        errors++;
        wrap_up();
    end
endtask : acc

task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
endtask : wr

task automatic rd_chk(input string what, input logic [4:0] a,
                      input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(what, {8'h00, exp}, {8'h00, q});
endtask : rd_chk

// cycles until the pin level changes; bounded
task automatic edge_wait(output int n);
    logic p;
    p = o_pin_out;
    n = 0;
    do
    begin
        @(posedge i_clk);
        n++;
    end
    while (o_pin_out === p && n < 5000);
    if (n >= 5000)
    begin
        errors++;
        wrap_up();
    end
endtask : edge_wait

// ============================================================
// scenarios
task automatic t_reset;
    logic [4:0] ofs [7];
    ofs = '{tm8_pkg::OFS_CTRL, tm8_pkg::OFS_COUNT, tm8_pkg::OFS_COMPARE,
            tm8_pkg::OFS_FLAGS, tm8_pkg::OFS_IRQ_EN, tm8_pkg::OFS_PORT,
            5'h18};
    chk("oe_n_reset", 16'h0001, {15'h0000, o_pin_oe_n});
    foreach (ofs[i])
    begin
        rd_chk("reg_reset", ofs[i], 8'h00);
    end
    // clock stopped: the count stays where it was written
    wr(tm8_pkg::OFS_COUNT, 8'h55);
    cyc(10);
    rd_chk("count_frozen", tm8_pkg::OFS_COUNT, 8'h55);
endtask : t_reset

task automatic t_force;
    logic [1:0] act [5];
    logic ex [5];
    act = '{tm8_pkg::ACT_SET, tm8_pkg::ACT_CLEAR, tm8_pkg::ACT_TOGGLE,
            tm8_pkg::ACT_TOGGLE, tm8_pkg::ACT_SET};
    ex = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    wr(tm8_pkg::OFS_PORT, 8'h00);
    foreach (act[i])
    begin
        wr(tm8_pkg::OFS_CTRL, {1'b1, 3'b000, act[i], 2'b00});
        cyc(2);
        chk("forced_state", {15'h0000, ex[i]}, {15'h0000, o_pin_out});
    end
    chk("oe_n_input", 16'h0001, {15'h0000, o_pin_oe_n});
    // state was set up before the pin is turned to output
    wr(tm8_pkg::OFS_PORT, 8'h02);
    cyc(2);
    chk("oe_n_output", 16'h0000, {15'h0000, o_pin_oe_n});
    wr(tm8_pkg::OFS_CTRL, 8'h80);
    cyc(2);
    chk("port_bit_shown", 16'h0000, {15'h0000, o_pin_out});
    wr(tm8_pkg::OFS_CTRL, 8'h0C);
    cyc(2);
    chk("state_kept", 16'h0001, {15'h0000, o_pin_out});
    rd_chk("force_no_flag", tm8_pkg::OFS_FLAGS, 8'h00);
    rd_chk("force_no_count", tm8_pkg::OFS_COUNT, 8'h55);
    wr(tm8_pkg::OFS_PORT, 8'h00);
    cyc(2);
    chk("oe_n_released", 16'h0001, {15'h0000, o_pin_oe_n});
endtask : t_force

task automatic t_ovf;
    logic [7:0] q;
    wr(tm8_pkg::OFS_CTRL, 8'h00);
    wr(tm8_pkg::OFS_COMPARE, 8'h80);
    wr(tm8_pkg::OFS_IRQ_EN, 8'h01);
    wr(tm8_pkg::OFS_CTRL, 8'h10);
    // written while counting: the write must win over the increment
    wr(tm8_pkg::OFS_COUNT, 8'hFD);
    cyc(10);
    wr(tm8_pkg::OFS_CTRL, 8'h00);
    acc(1'b0, tm8_pkg::OFS_COUNT, 8'h00, q);
    chk("count_wrapped", 16'h0001, {15'h0000, q < 8'h20});
    rd_chk("ovf_flag", tm8_pkg::OFS_FLAGS, 8'h01);
    chk("ovf_irq", 16'h0001, {15'h0000, o_ovf_irq});
    @(posedge i_clk);
    ovf_ack <= 1'b1;
    @(posedge i_clk);
    ovf_ack <= 1'b0;
    cyc(2);
    rd_chk("ovf_serviced", tm8_pkg::OFS_FLAGS, 8'h00);
    chk("ovf_irq_off", 16'h0000, {15'h0000, o_ovf_irq});
    wr(tm8_pkg::OFS_IRQ_EN, 8'h00);
endtask : t_ovf

task automatic t_block;
    // count written equal to compare: that match must be lost
    wr(tm8_pkg::OFS_CTRL, 8'h02);
    wr(tm8_pkg::OFS_COMPARE, 8'h10);
    wr(tm8_pkg::OFS_COUNT, 8'h10);
    cyc(5);
    wr(tm8_pkg::OFS_CTRL, 8'h12);
    cyc(100);
    wr(tm8_pkg::OFS_CTRL, 8'h02);
    rd_chk("blocked_match", tm8_pkg::OFS_FLAGS, 8'h00);
    // top below count: runs through max and wraps before matching
    wr(tm8_pkg::OFS_COMPARE, 8'h05);
    wr(tm8_pkg::OFS_CTRL, 8'h12);
    cyc(200);
    wr(tm8_pkg::OFS_CTRL, 8'h02);
    rd_chk("missed_top", tm8_pkg::OFS_FLAGS, 8'h03);
    wr(tm8_pkg::OFS_FLAGS, 8'h03);
endtask : t_block

task automatic t_toggle;
    int div [7];
    int n;
    div = '{1, 8, 32, 64, 128, 256, 1024};
    wr(tm8_pkg::OFS_CTRL, 8'h06);
    wr(tm8_pkg::OFS_COMPARE, 8'h03);
    wr(tm8_pkg::OFS_COUNT, 8'h00);
    wr(tm8_pkg::OFS_IRQ_EN, 8'h02);
    wr(tm8_pkg::OFS_PORT, 8'h02);
    for (int s = 1; s <= 7; s++)
    begin
        wr(tm8_pkg::OFS_CTRL, {1'b0, 3'(s), 4'b0110});
        edge_wait(n);
        edge_wait(n);
        edge_wait(n);
        chk("half_period", 16'(4 * div[s - 1]), 16'(n));
    end
    chk("cmp_irq", 16'h0001, {15'h0000, o_cmp_irq});
    wr(tm8_pkg::OFS_CTRL, 8'h1A);
    cyc(12);
    chk("act_clear_now", 16'h0000, {15'h0000, o_pin_out});
    wr(tm8_pkg::OFS_CTRL, 8'h1E);
    cyc(12);
    chk("act_set_now", 16'h0001, {15'h0000, o_pin_out});
    // matches keep coming with action zero; the state must stay set
    wr(tm8_pkg::OFS_CTRL, 8'h12);
    cyc(12);
    wr(tm8_pkg::OFS_CTRL, 8'h06);
    cyc(2);
    chk("act_none_run", 16'h0001, {15'h0000, o_pin_out});
    wr(tm8_pkg::OFS_CTRL, 8'h04);
    cyc(2);
    chk("state_on_mode_change", 16'h0001, {15'h0000, o_pin_out});
    rd_chk("cmp_flag_only", tm8_pkg::OFS_FLAGS, 8'h02);
    wr(tm8_pkg::OFS_FLAGS, 8'h02);
    rd_chk("cmp_flag_w1c", tm8_pkg::OFS_FLAGS, 8'h00);
    wr(tm8_pkg::OFS_CTRL, 8'h12);
    cyc(8);
    wr(tm8_pkg::OFS_CTRL, 8'h02);
    rd_chk("cmp_flag_again", tm8_pkg::OFS_FLAGS, 8'h02);
    @(posedge i_clk);
    cmp_ack <= 1'b1;
    @(posedge i_clk);
    cmp_ack <= 1'b0;
    cyc(2);
    rd_chk("cmp_flag_ack", tm8_pkg::OFS_FLAGS, 8'h00);
    chk("cmp_irq_off", 16'h0000, {15'h0000, o_cmp_irq});
endtask : t_toggle

// ============================================================
// main sequence
initial
begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_force();
    t_ovf();
    t_block();
    t_toggle();
    wrap_up();
end

endmodule : tb_top
